/* logic/ecp_pkg.sv */
// Shared constants, modes and engine states of the ECP parallel host port
// Behaviour
// RULE1: One 16-byte FIFO buffers bytes in both forward and reverse directions.
// RULE2: System side is a valid/ready burst channel with a DMA request output.
// RULE3: Compatibility FIFO mode runs the strobe/busy handshake in hardware.
// RULE4: Received ECP data is always run-length decompressed in hardware.
// RULE5: Run-length byte is consumed; following data byte repeats count plus one times.
// RULE6: Hardware compression is optional and is not provided here.
// RULE7: Forward byte is captured on nStrobe falling edge, interlocked with Busy.
// RULE8: Forward strobe waits for Busy low, then for Busy high, then low again.
// RULE9: Reverse: peripheral Busy low marks command byte, high marks data byte.
// RULE10: Reverse: nAck low marks valid data, interlocked with nAutoFd.
// RULE11: Reverse: host drives nAutoFd low to request each byte.
// RULE12: Forward: nAutoFd low marks address/command byte, high marks data.
// RULE13: Peripheral drives PError low to acknowledge reverse request on nInit.
// RULE14: Host drives data bus only while PError reads high in forward.
// RULE15: nFault asserted in forward direction raises the error interrupt output.
// RULE16: nFault low in ECP mode is only a reverse hint; host keeps direction.
// RULE17: nInit low selects reverse direction, high selects forward.
// RULE18: Peripheral drives data only in ECP mode, HostAck low, nSelectIn high.
// RULE19: nSelectIn is held deasserted (high) throughout ECP mode.
// RULE20: Data lines carry address, data or run-length count per HostAck/Busy tag.
// RULE21: ECP protocol runs only while the mode input holds 011.
// RULE22: Bytes written with the address tag are queued tagged and sent automatically.
// RULE23: Expanded bytes enter the FIFO one per slot; handshake stalls while full.
package ecp_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = BYTE_W + 1;
  localparam int TAG_BIT = 8;
  localparam int RLE_FLAG_BIT = 7;
  localparam logic [2:0] MODE_COMPAT_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam int CLK_MHZ = 125;
  localparam int STROBE_NS = 500;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_W = 13;
  // Filter reset: select, fault, error and ack idle high, busy and data low
  localparam logic [SYNC_W-1:0] PIN_IDLE = 13'h1E00;

  typedef enum logic [3:0] {
    ECP_IDLE,
    ECP_F_WAIT,
    ECP_F_STB,
    ECP_F_REL,
    ECP_TURN_REV,
    ECP_TURN_FWD,
    ECP_R_REQ,
    ECP_R_REL,
    ECP_R_EXPAND
  } ecp_state_e;
endpackage

/* logic/ecp_fifo_if.sv */
// Push/pop carrier between the port engine and its byte FIFO
interface ecp_fifo_if #(parameter int W = 9) ();
  logic push_valid;
  logic [W-1:0] push_data;
  logic push_ready;
  logic pop_valid;
  logic [W-1:0] pop_data;
  logic pop_ready;
  logic full;
  logic empty;
  modport store (input push_valid, input push_data, output push_ready,
                 output pop_valid, output pop_data, input pop_ready,
                 output full, output empty);
  modport user (output push_valid, output push_data, input push_ready,
                input pop_valid, input pop_data, output pop_ready,
                input full, input empty);
endinterface

/* logic/ecp_fifo.sv */
// Tagged byte FIFO shared by both transfer directions
module ecp_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  ecp_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic do_push, do_pop;

  // Full and empty from pointer wrap bit
  always_comb begin
    f.full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    f.empty = (wp == rp);
    f.push_ready = !f.full;
    f.pop_valid = !f.empty;
    f.pop_data = mem[rp[AW-1:0]];
    do_push = f.push_valid && !f.full;
    do_pop = f.pop_ready && !f.empty;
    next_wp = do_push ? wp + (AW+1)'(1) : wp;
    next_rp = do_pop ? rp + (AW+1)'(1) : rp;
  end

  // Pointers reset; storage needs none
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (do_push) begin
      mem[wp[AW-1:0]] <= f.push_data;
    end
  end
endmodule

/* logic/ecp_port.sv */
// ECP parallel port host engine with FIFO, handshakes and RLE expansion
module ecp_port #(
  parameter int DEPTH = ecp_pkg::FIFO_DEPTH,
  parameter int STB_CYC = ecp_pkg::STROBE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [2:0] mode_in,
  input wire logic direction_in,
  input wire logic dma_en_in,
  input wire logic wr_valid_in,
  input wire logic [ecp_pkg::BYTE_W-1:0] wr_data_in,
  input wire logic wr_addr_tag_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [ecp_pkg::BYTE_W-1:0] rd_data_out,
  output logic rd_cmd_tag_out,
  input wire logic rd_ready_in,
  output logic dma_req_out,
  output logic fifo_full_out,
  output logic fifo_empty_out,
  output logic reverse_out,
  output logic error_irq_out,
  output logic reverse_hint_out,
  output logic strobe_n_out,
  output logic autofd_n_out,
  output logic init_n_out,
  output logic select_in_n_out,
  input wire logic [ecp_pkg::BYTE_W-1:0] pd_in,
  output logic [ecp_pkg::BYTE_W-1:0] pd_out,
  output logic pd_oe_out,
  input wire logic busy_in,
  input wire logic ack_n_in,
  input wire logic perror_in,
  input wire logic fault_n_in,
  input wire logic select_in
);
  import ecp_pkg::*;

  ecp_fifo_if #(.W(FIFO_W)) fq ();

  ecp_fifo #(.W(FIFO_W), .DEPTH(DEPTH)) u_fifo ( // RULE1
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .f(fq.store)
  );

  // Pin filter: three stages, a change counts once stages two and three agree
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] next_pins;
  assign raw = {select_in, fault_n_in, perror_in, ack_n_in, busy_in, pd_in};

  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      next_pins[i] = (s2[i] == s3[i]) ? s2[i] : pins[i];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1 <= PIN_IDLE; // Idle levels, so no false fault or ack after reset
      s2 <= PIN_IDLE;
      s3 <= PIN_IDLE;
      pins <= PIN_IDLE;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      pins <= next_pins;
    end
  end

  logic [BYTE_W-1:0] pd_s;
  logic busy_s;
  logic ack_n_s;
  logic perror_s;
  logic fault_n_s;
  assign pd_s = pins[BYTE_W-1:0];
  assign busy_s = pins[8];
  assign ack_n_s = pins[9];
  assign perror_s = pins[10];
  assign fault_n_s = pins[11];

  // Mode decode
  logic ecp_mode;
  logic compat_mode;
  logic active;
  assign ecp_mode = (mode_in == MODE_ECP); // RULE21
  assign compat_mode = (mode_in == MODE_COMPAT_FIFO);
  assign active = ecp_mode || compat_mode;

  // Engine state
  ecp_state_e state;
  ecp_state_e next_state;
  logic rev;
  logic next_rev;
  logic strobe_n;
  logic next_strobe_n;
  logic autofd_n;
  logic next_autofd_n;
  logic init_n;
  logic next_init_n;
  logic [BYTE_W-1:0] pd_q;
  logic [BYTE_W-1:0] next_pd_q;
  logic pd_oe;
  logic next_pd_oe;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic [6:0] rle_cnt;
  logic [6:0] next_rle_cnt;
  logic rle_armed;
  logic next_rle_armed;
  logic [7:0] rep_left;
  logic [7:0] next_rep_left;
  logic [BYTE_W-1:0] rep_byte;
  logic [BYTE_W-1:0] next_rep_byte;
  logic rep_tag;
  logic next_rep_tag;
  logic irq;
  logic next_irq;
  logic hint;
  logic next_hint;
  logic eng_pop;
  logic eng_push;

  // FIFO steering: system fills it forward, engine fills it in reverse
  always_comb begin
    eng_push = (state == ECP_R_EXPAND);
    fq.push_valid = rev ? eng_push : (wr_valid_in && active);
    fq.push_data = rev ? {rep_tag, rep_byte} : {wr_addr_tag_in, wr_data_in}; // RULE22
    fq.pop_ready = rev ? rd_ready_in : eng_pop;
    wr_ready_out = !rev && active && fq.push_ready;
    rd_valid_out = rev && fq.pop_valid;
    // Forward DMA asks for room, reverse DMA asks for data
    dma_req_out = dma_en_in && active && (rev ? fq.pop_valid : fq.push_ready); // RULE2
  end

  assign rd_data_out = fq.pop_data[BYTE_W-1:0];
  assign rd_cmd_tag_out = fq.pop_data[TAG_BIT];
  assign fifo_full_out = fq.full;
  assign fifo_empty_out = fq.empty;

  // Next state of the handshake engine
  always_comb begin
    next_state = state;
    next_rev = rev;
    next_strobe_n = strobe_n;
    next_autofd_n = autofd_n;
    next_init_n = init_n;
    next_pd_q = pd_q;
    next_tmr = tmr;
    next_rle_cnt = rle_cnt;
    next_rle_armed = rle_armed;
    next_rep_left = rep_left;
    next_rep_byte = rep_byte;
    next_rep_tag = rep_tag;
    eng_pop = 1'b0;
    // Error only meaningful forward; a pending turn round already counts as reverse
    next_irq = ecp_mode && !rev && init_n && !fault_n_s; // RULE15
    // Hint is reported only; direction stays with direction_in
    next_hint = ecp_mode && !fault_n_s; // RULE16
    if (!active) begin
      // Leaving the protocol modes abandons any transfer
      next_state = ECP_IDLE;
      next_rev = 1'b0;
      next_strobe_n = 1'b1;
      next_autofd_n = 1'b1;
      next_init_n = 1'b1;
      next_rle_armed = 1'b0;
    end else begin
      case (state)
        // Idle: next forward byte, next reverse request, or a turn round
        ECP_IDLE: begin
          if (!rev) begin
            // Drain forward bytes before turning the link round
            if (fq.pop_valid && (compat_mode || perror_s)) begin // RULE14
              eng_pop = 1'b1;
              next_pd_q = fq.pop_data[BYTE_W-1:0]; // RULE20
              // No compression: bytes leave as queued
              next_autofd_n = compat_mode ? 1'b1 : !fq.pop_data[TAG_BIT]; // RULE12 RULE6
              next_state = ECP_F_WAIT;
            end else if (ecp_mode && direction_in && fq.empty) begin
              next_init_n = 1'b0; // RULE17
              next_state = ECP_TURN_REV;
            end
          end else if (!direction_in) begin
            next_init_n = 1'b1; // RULE17
            next_state = ECP_TURN_FWD;
          end else if (fq.push_ready && rep_left == 8'h00) begin
            // Request a byte only when a slot is free
            next_autofd_n = 1'b0; // RULE11 RULE23
            next_state = ECP_R_REQ;
          end
        end

        // Forward: wait until the peripheral can take a byte
        ECP_F_WAIT: begin
          if (!busy_s) begin
            next_strobe_n = 1'b0; // RULE7 RULE3
            next_tmr = 16'(STB_CYC - 1);
            next_state = ECP_F_STB;
          end
        end

        // Forward: strobe low until busy answers or the timer runs out
        ECP_F_STB: begin
          if (compat_mode) begin
            if (tmr == 16'h0000) begin
              next_strobe_n = 1'b1; // RULE3
              next_state = ECP_F_REL;
            end else begin
              next_tmr = tmr - 16'h0001;
            end
          end else if (busy_s) begin
            next_strobe_n = 1'b1; // RULE8
            next_state = ECP_F_REL;
          end
        end

        // Forward: strobe high again, busy must fall before the next byte
        ECP_F_REL: begin
          // Compatibility peers are paced by busy before the next strobe
          if (compat_mode || !busy_s) begin // RULE8
            next_autofd_n = 1'b1;
            next_state = ECP_IDLE;
          end
        end

        // Reverse asked for: bus already released, wait for the acknowledge
        ECP_TURN_REV: begin
          if (!perror_s) begin
            next_rev = 1'b1; // RULE13
            next_state = ECP_IDLE;
          end
        end

        // Forward asked for: wait until the peripheral frees the bus
        ECP_TURN_FWD: begin
          if (perror_s) begin
            next_rev = 1'b0; // RULE13
            next_rle_armed = 1'b0;
            next_state = ECP_IDLE;
          end
        end

        // Reverse: byte requested, wait for the peripheral to mark it valid
        ECP_R_REQ: begin
          if (!ack_n_s) begin
            next_rep_byte = pd_s; // RULE10
            next_rep_tag = !busy_s; // RULE9
            next_autofd_n = 1'b1; // RULE10
            next_state = ECP_R_REL;
          end else if (!direction_in) begin
            // Withdraw an unanswered request, else turning forward hangs
            next_autofd_n = 1'b1; // RULE11
            next_state = ECP_IDLE;
          end
        end

        // Reverse: byte taken, wait for the peripheral to end its cycle
        ECP_R_REL: begin
          if (ack_n_s) begin
            if (rep_tag && !rep_byte[RLE_FLAG_BIT]) begin
              // Run-length count is swallowed, not queued
              next_rle_cnt = rep_byte[6:0]; // RULE4 RULE5
              next_rle_armed = 1'b1;
              next_state = ECP_IDLE;
            end else if (rep_tag) begin
              next_rep_left = 8'h01;
              next_state = ECP_R_EXPAND;
            end else begin
              next_rep_left = rle_armed ? {1'b0, rle_cnt} + 8'h01 : 8'h01; // RULE5
              next_rle_armed = 1'b0;
              next_state = ECP_R_EXPAND;
            end
          end
        end

        // Reverse: write out the captured byte, once or as a run
        ECP_R_EXPAND: begin
          // One copy per free slot; the link stays idle meanwhile
          if (fq.push_ready) begin // RULE23
            next_rep_left = rep_left - 8'h01;
            if (rep_left == 8'h01) begin
              next_state = ECP_IDLE;
            end
          end
        end

        // Unused encodings fall back to idle
        default: begin
          next_state = ECP_IDLE;
        end
      endcase
    end
    // Bus released whenever reverse is requested or acknowledged
    next_pd_oe = active && !next_rev && next_init_n &&
                 (compat_mode || perror_s); // RULE14
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= ECP_IDLE;
      rev <= 1'b0;
      strobe_n <= 1'b1;
      autofd_n <= 1'b1;
      init_n <= 1'b1;
      pd_q <= 8'h00;
      pd_oe <= 1'b0;
      tmr <= 16'h0000;
      rle_cnt <= 7'h00;
      rle_armed <= 1'b0;
      rep_left <= 8'h00;
      rep_byte <= 8'h00;
      rep_tag <= 1'b0;
      irq <= 1'b0;
      hint <= 1'b0;
    end else begin
      state <= next_state;
      rev <= next_rev;
      strobe_n <= next_strobe_n;
      autofd_n <= next_autofd_n;
      init_n <= next_init_n;
      pd_q <= next_pd_q;
      pd_oe <= next_pd_oe;
      tmr <= next_tmr;
      rle_cnt <= next_rle_cnt;
      rle_armed <= next_rle_armed;
      rep_left <= next_rep_left;
      rep_byte <= next_rep_byte;
      rep_tag <= next_rep_tag;
      irq <= next_irq;
      hint <= next_hint;
    end
  end

  // Pin outputs from flip-flops, nSelectIn tied high
  assign strobe_n_out = strobe_n;
  assign autofd_n_out = autofd_n;
  assign init_n_out = init_n;
  assign select_in_n_out = 1'b1; // RULE19 RULE18
  assign pd_out = pd_q;
  assign pd_oe_out = pd_oe;
  assign reverse_out = rev;
  assign error_irq_out = irq;
  assign reverse_hint_out = hint;
endmodule

/* tb/ecp_port_props.sv */
// Concurrent checks on the ECP host port pins and system side
module ecp_port_props
  import ecp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [2:0] mode_in,
  input wire logic direction_in,
  input wire logic wr_ready_out,
  input wire logic reverse_out,
  input wire logic error_irq_out,
  input wire logic reverse_hint_out,
  input wire logic strobe_n_out,
  input wire logic autofd_n_out,
  input wire logic init_n_out,
  input wire logic select_in_n_out,
  input wire logic [BYTE_W-1:0] pd_out,
  input wire logic pd_oe_out,
  input wire logic busy_in,
  input wire logic ack_n_in,
  input wire logic fault_n_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Interlock steps; five or six samples outlast the pin filter delay
  sequence s_stb_busy_low;
    mode_in == MODE_ECP && !strobe_n_out && !busy_in;
  endsequence
  sequence s_wait_ack;
    mode_in == MODE_ECP && reverse_out && direction_in && !autofd_n_out && ack_n_in;
  endsequence
  sequence s_fault_fwd;
    mode_in == MODE_ECP && !reverse_out && init_n_out && !fault_n_in;
  endsequence
  property p_sel_high; select_in_n_out; endproperty
  property p_stb_hold; s_stb_busy_low [*6] |=> !strobe_n_out; endproperty
  property p_ack_hold; s_wait_ack [*5] |=> !autofd_n_out; endproperty
  property p_pd_hold; !strobe_n_out |-> $stable(pd_out) && $stable(autofd_n_out); endproperty
  property p_oe_rev; reverse_out |-> !pd_oe_out && !wr_ready_out; endproperty
  property p_init_dir; $fell(init_n_out) |-> $past(direction_in) && $past(mode_in) == MODE_ECP;
  endproperty
  property p_irq_set; s_fault_fwd [*6] |=> error_irq_out; endproperty
  property p_irq_rev; error_irq_out |-> !($past(reverse_out) && !$past(init_n_out)); endproperty
  property p_hint; (mode_in == MODE_ECP && !fault_n_in) [*6] |=> reverse_hint_out; endproperty
  a_sel_high: assert property (p_sel_high) else $error("select asserted");
  a_stb_hold: assert property (p_stb_hold) else $error("strobe left early");
  a_ack_hold: assert property (p_ack_hold) else $error("request dropped");
  a_pd_hold: assert property (p_pd_hold) else $error("byte moved in strobe");
  a_oe_rev: assert property (p_oe_rev) else $error("host drives in reverse");
  a_init_dir: assert property (p_init_dir) else $error("init without request");
  a_irq_set: assert property (p_irq_set) else $error("fault irq missing");
  a_irq_rev: assert property (p_irq_rev) else $error("fault irq in reverse");
  a_hint: assert property (p_hint) else $error("hint missing");
endmodule
bind ecp_port ecp_port_props chk_u (.ref_clk_in, .reset_in, .mode_in, .direction_in,
  .wr_ready_out, .reverse_out, .error_irq_out, .reverse_hint_out, .strobe_n_out,
  .autofd_n_out, .init_n_out, .select_in_n_out, .pd_out, .pd_oe_out, .busy_in,
  .ack_n_in, .fault_n_in);

/* tb/ecp_periph_model.sv */
// Behavioural ECP peripheral answering the host port pins
module ecp_periph_model (
  input wire logic clk_in,
  input wire logic strobe_n_in,
  input wire logic autofd_n_in,
  input wire logic init_n_in,
  input wire logic [7:0] host_pd_in,
  output logic busy_out = 1'b0,
  output logic ack_n_out = 1'b1,
  output logic perror_out = 1'b1,
  output logic [7:0] pd_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] fwd_q[$];
  logic [8:0] rev_q[$];
  logic stall = 1'b0;
  int lag = 1;
  // Forward: capture on strobe fall, then busy interlock
  initial forever begin
    @(negedge strobe_n_in);
    fwd_q.push_back({autofd_n_in, host_pd_in});
    repeat (lag) @(posedge clk_in);
    #1 busy_out = 1'b1;
    wait (strobe_n_in && !stall);
    @(posedge clk_in);
    #1 busy_out = 1'b0;
  end
  // Direction: answer the host request a few cycles late
  initial forever begin
    @(init_n_in);
    repeat (3) @(posedge clk_in);
    #1 perror_out = init_n_in;
    if (init_n_in) busy_out = 1'b0;
  end
  // Reverse: one byte per request, command flagged by busy low
  initial forever begin
    @(posedge clk_in);
    if (!init_n_in && !perror_out && !autofd_n_in && rev_q.size() > 0) begin
      #1 busy_out = !rev_q[0][8];
      pd_out = rev_q[0][7:0];
      rev_q.delete(0);
      repeat (lag + 1) @(posedge clk_in);
      #1 ack_n_out = 1'b0;
      wait (autofd_n_in);
      @(posedge clk_in);
      #1 ack_n_out = 1'b1;
      pd_out = ~pd_out; // Released lines must not keep the old byte
    end
  end
endmodule

/* tb/ecp_port_tb.sv */
// Self-checking bench for the ECP host port
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, a, e); end end
module ecp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset = 1, dir = 0, wv = 0, wt = 0, rr = 0, fault_n = 1;
  logic dma_en = 1, sel = 1;
  logic [2:0] mode = 3'h0;
  logic [7:0] wd = 8'h00, hpd, mpd, rdat;
  logic wrdy, rv, rtag, dreq, full, empty, rev, irq, hint, stb_n, afd_n, ini_n, sel_n, oe;
  logic busy, ack_n, perr;
  wire logic [7:0] bus = oe ? hpd : mpd;
  int n_errors = 0, n_checks = 0;
  // 125 MHz clock
  initial forever #4 ref_clk = ~ref_clk;
  ecp_port #(.STB_CYC(2)) dut_u (.ref_clk_in(ref_clk), .reset_in(reset), .mode_in(mode),
    .direction_in(dir), .dma_en_in(dma_en), .wr_valid_in(wv), .wr_data_in(wd),
    .wr_addr_tag_in(wt), .wr_ready_out(wrdy), .rd_valid_out(rv), .rd_data_out(rdat),
    .rd_cmd_tag_out(rtag), .rd_ready_in(rr), .dma_req_out(dreq), .fifo_full_out(full),
    .fifo_empty_out(empty), .reverse_out(rev), .error_irq_out(irq),
    .reverse_hint_out(hint), .strobe_n_out(stb_n), .autofd_n_out(afd_n),
    .init_n_out(ini_n), .select_in_n_out(sel_n), .pd_in(bus), .pd_out(hpd),
    .pd_oe_out(oe), .busy_in(busy), .ack_n_in(ack_n), .perror_in(perr),
    .fault_n_in(fault_n), .select_in(sel));
  ecp_periph_model per_u (.clk_in(ref_clk), .strobe_n_in(stb_n), .autofd_n_in(afd_n),
    .init_n_in(ini_n), .host_pd_in(bus), .busy_out(busy), .ack_n_out(ack_n),
    .perror_out(perr), .pd_out(mpd));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin tick(1); k++; end
    if (s !== v) begin n_errors++; $display("MISMATCH %0t wait timed out", $time); finish_test(); end
  endtask
  // Valid held until taken; caller lowers it
  task automatic wr(input logic [8:0] v, input int lim, output bit ok);
    int k;
    k = 0;
    wv = 1'b1;
    {wt, wd} = v;
    while (wrdy !== 1'b1 && k < lim) begin tick(1); k++; end
    ok = (wrdy === 1'b1);
    if (ok) tick(1);
  endtask
  task automatic fwd_chk(input logic [8:0] e[$]);
    int k;
    k = 0;
    while (per_u.fwd_q.size() < e.size() && k < 3000) begin tick(1); k++; end
    // A link that never delivers ends the run
    if (per_u.fwd_q.size() < e.size()) begin
      n_errors++;
      $display("MISMATCH %0t link timed out", $time);
      finish_test();
    end
    foreach (e[i]) `CHK(per_u.fwd_q[i], e[i])
    per_u.fwd_q.delete();
  endtask
  task automatic drain(input logic [8:0] e[$]);
    int k;
    logic [8:0] x;
    k = 0;
    rr = 1'b1;
    while (e.size() > 0 && k < 3000) begin
      // Pop once, the macro names its expected value twice
      if (rv === 1'b1) begin
        x = e.pop_front();
        `CHK({rtag, rdat}, x)
      end
      tick(1);
      k++;
    end
    rr = 1'b0;
    `CHK(e.size(), 0)
    if (e.size() > 0) finish_test();
  endtask
  task automatic t_reset;
    `CHK({stb_n, afd_n, ini_n, sel_n, oe, rev, empty}, 7'h79)
  endtask
  task automatic t_ecp_fwd;
    logic [8:0] e[$];
    bit ok;
    per_u.lag = 8;
    mode = 3'h3;
    wait_for(oe, 1'b1, 30);
    `CHK(dreq, 1'b1)
    dma_en = 1'b0;
    tick(1);
    `CHK(dreq, 1'b0)
    dma_en = 1'b1;
    e = '{9'h155, 9'h0AA, 9'h0FF};
    foreach (e[i]) begin wr(e[i], 40, ok); `CHK(ok, 1'b1) end
    wv = 1'b0;
    fwd_chk('{9'h055, 9'h1AA, 9'h1FF});
    // Stalled peripheral: FIFO must fill and refuse
    per_u.lag = 1;
    per_u.stall = 1'b1;
    e.delete();
    for (int i = 0; i < 20; i++) begin
      wr({1'b0, 8'(i)}, 40, ok);
      if (!ok) break;
      e.push_back({1'b1, 8'(i)});
    end
    `CHK({full, dreq, e.size() inside {16, 17}}, 3'h5)
    wv = 1'b0;
    per_u.stall = 1'b0;
    fwd_chk(e);
    `CHK(empty, 1'b1)
  endtask
  task automatic t_compat;
    bit ok;
    mode = 3'h2;
    wr(9'h13C, 40, ok);
    `CHK(ok, 1'b1)
    wr(9'h0C3, 40, ok);
    `CHK(ok, 1'b1)
    wv = 1'b0;
    fwd_chk('{9'h13C, 9'h1C3});
  endtask
  task automatic t_reverse;
    logic [8:0] e[$];
    per_u.lag = 8;
    mode = 3'h3;
    fault_n = 1'b0;
    tick(10);
    `CHK({irq, hint, rev}, 3'h6)
    dir = 1'b1;
    wait_for(rev, 1'b1, 60);
    `CHK({oe, irq, hint}, 3'h1)
    per_u.rev_q = '{9'h17F, 9'h05A, 9'h185, 9'h011};
    wait_for(full, 1'b1, 600);
    tick(30);
    `CHK({afd_n, dreq}, 2'h3)
    repeat (128) e.push_back(9'h05A);
    e.push_back(9'h185);
    e.push_back(9'h011);
    drain(e);
    fault_n = 1'b1;
    dir = 1'b0;
    wait_for(rev, 1'b0, 60);
    wait_for(oe, 1'b1, 30);
    mode = 3'h0;
    tick(2);
    `CHK({wrdy, stb_n, afd_n, ini_n}, 4'h7)
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_reset();
    t_ecp_fwd();
    t_compat();
    t_reverse();
    finish_test();
  end
endmodule
